// file: shp_homing_loop.sv
/*
 * shp_homing_loop: homing sequencer, actual position counter, position loop
 * correction and register port of a servo drive's positioning logic.
 * Assumes limit switch pins are asynchronous, current, speed and position
 * deltas come from logic on clk, and a plain register master on clk.
 */
// Operation
// - homing speed changes are ramped linearly even with setpoint ramps off
// - approach the limit switch at the first homing speed
// - locate switch edge or push the stop at the second homing speed
// - homing ends at switch transition or on reaching the mechanical stop
// - at the end load minus home offset into actual position
// - during a run correction around trajectory speed is capped by limit
// - after a run hold target position, speed capped by correction limit
// - homing starts on a 0 to 1 change of control bit 4
// - mechanical stop seen as current rise with motor speed at zero
// - at the start speed steps from the loop demand to zero at once, then homing acceleration governs it; at the end it passes to the loop demand at once
`timescale 1ns/1ps
`default_nettype none
module shp_homing_loop #(
	parameter int RAMP_TICK_CYCLES = shp_pkg::RAMP_TICK_CYCLES
) (
	input  wire logic               clk,
	input  wire logic               resetn,
	input  wire logic        [7:0]  addr,
	input  wire logic        [31:0] wdata,
	input  wire logic               wr,
	input  wire logic               rd,
	output logic             [31:0] rdata,
	input  wire logic               posLimit,
	input  wire logic               negLimit,
	input  wire logic        [15:0] motorCurrent,
	input  wire logic signed [31:0] motorSpeed,
	input  wire logic signed [15:0] posDelta,
	output logic signed      [31:0] speedCmd,
	output logic signed      [31:0] actualPos,
	output logic                    homingBusy,
	output logic                    homingDone
);
	localparam int TW = $clog2(RAMP_TICK_CYCLES + 1);

	function automatic logic signed [31:0] sat(input logic signed [31:0] v,
	                                           input logic signed [31:0] lim);
		sat = (v > lim) ? lim : (v < -lim) ? -lim : v;
	endfunction

	function automatic logic signed [31:0] withDir(input logic neg,
	                                               input logic signed [31:0] v);
		withDir = neg ? -v : v;
	endfunction

	// software registers
	logic        [31:0] ctrl;
	logic        [1:0]  method;
	logic signed [31:0] speed1;
	logic signed [31:0] speed2;
	logic        [31:0] accel;
	logic signed [31:0] homeOffset;
	logic        [15:0] curThr;
	logic signed [31:0] corrLim;
	logic        [15:0] kp;
	logic signed [31:0] demPos;
	logic signed [31:0] trajSpeed;

	shp_pkg::shp_home_state_t state;
	shp_pkg::shp_home_state_t next_state;

	logic [2:0]    posSync;
	logic [2:0]    negSync;
	logic [1:0]    limitStable;
	logic [TW-1:0] tickCnt;
	logic          tick;

	shp_ramp_if rampBus ();

	// address decode
	wire wrCtrl   = wr && (addr == shp_pkg::REG_CTRL);
	wire homeReq  = wrCtrl && wdata[shp_pkg::CTRL_HOME_BIT]
	                && !ctrl[shp_pkg::CTRL_HOME_BIT];
	wire dirNeg   = method[shp_pkg::METH_NEG_BIT];
	wire useStop  = method[shp_pkg::METH_STOP_BIT];
	wire swSel    = dirNeg ? limitStable[1] : limitStable[0];
	wire stopHit  = (motorCurrent >= curThr) && (motorSpeed == 32'sh0);
	wire runActive = ctrl[shp_pkg::CTRL_RUN_BIT];

	// synchronisers: the first stage feeds only the second
	always_ff @(posedge clk) begin
		if (!resetn) begin
			posSync <= 3'h0;
			negSync <= 3'h0;
		end else begin
			posSync <= {posSync[1:0], posLimit};
			negSync <= {negSync[1:0], negLimit};
		end
	end

	// a change counts only once the second and third stages agree
	always_ff @(posedge clk) begin
		if (!resetn) begin
			limitStable <= 2'h0;
		end else begin
			if (posSync[1] == posSync[2]) limitStable[0] <= posSync[2];
			if (negSync[1] == negSync[2]) limitStable[1] <= negSync[2];
		end
	end

	// ramp timebase: one pulse per millisecond
	assign tick = (tickCnt == TW'(RAMP_TICK_CYCLES - 1));
	always_ff @(posedge clk) begin
		if (!resetn || tick) tickCnt <= '0;
		else tickCnt <= tickCnt + 1'b1;
	end

	// register writes; status and position are read-only
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ctrl <= shp_pkg::RST_ZERO;
			method <= 2'h0;
			speed1 <= shp_pkg::RST_ZERO;
			speed2 <= shp_pkg::RST_ZERO;
			accel <= shp_pkg::RST_ZERO;
			homeOffset <= shp_pkg::RST_ZERO;
			curThr <= shp_pkg::RST_CURTHR;
			corrLim <= shp_pkg::RST_CORRLIM;
			kp <= shp_pkg::RST_KP;
			demPos <= shp_pkg::RST_ZERO;
			trajSpeed <= shp_pkg::RST_ZERO;
		end else if (wr) begin
			unique case (addr)
				shp_pkg::REG_CTRL:    ctrl <= wdata;
				shp_pkg::REG_METHOD:  method <= wdata[1:0];
				shp_pkg::REG_SPEED1:  speed1 <= wdata;
				shp_pkg::REG_SPEED2:  speed2 <= wdata;
				shp_pkg::REG_ACCEL:   accel <= wdata;
				shp_pkg::REG_OFFSET:  homeOffset <= wdata; // range is the master's duty
				shp_pkg::REG_CURTHR:  curThr <= wdata[15:0];
				shp_pkg::REG_CORRLIM: corrLim <= wdata;
				shp_pkg::REG_KP:      kp <= wdata[15:0];
				shp_pkg::REG_DEMPOS:  demPos <= wdata;
				shp_pkg::REG_TRAJ:    trajSpeed <= wdata;
				default: ;
			endcase
		end
	end

	// homing sequencer; starts are ignored while homing is in progress
	always_comb begin
		next_state = state;
		unique case (state)
			shp_pkg::HS_IDLE:
				if (homeReq) next_state = useStop ? shp_pkg::HS_PUSH : shp_pkg::HS_APPROACH;
			shp_pkg::HS_APPROACH:
				if (swSel) next_state = shp_pkg::HS_LOCATE;
			shp_pkg::HS_LOCATE:
				if (!swSel) next_state = shp_pkg::HS_FINISH;
			shp_pkg::HS_PUSH:
				if (stopHit) next_state = shp_pkg::HS_FINISH;
			shp_pkg::HS_FINISH:
				next_state = shp_pkg::HS_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) state <= shp_pkg::HS_IDLE;
		else state <= next_state;
	end

	// ramp target: switch approach at speed 1, edge search and stop at speed 2
	assign rampBus.target = (state == shp_pkg::HS_APPROACH) ? withDir(dirNeg, speed1) :
	                        (state == shp_pkg::HS_LOCATE)   ? withDir(!dirNeg, speed2) :
	                        (state == shp_pkg::HS_PUSH)     ? withDir(dirNeg, speed2) :
	                        32'sh0;
	assign rampBus.step   = accel;
	assign rampBus.tick   = tick;
	assign rampBus.enable = (state != shp_pkg::HS_IDLE);

	shp_ramp u_ramp (
		.clk    (clk),
		.resetn (resetn),
		.rb     (rampBus)
	);

	// position loop: P term on the following error, clipped to the limit
	wire signed [31:0] posErr  = demPos - actualPos;
	wire signed [48:0] prod    = posErr * $signed({1'b0, kp});
	wire signed [31:0] corr    = sat(prod[shp_pkg::KP_FRAC +: 32], corrLim);
	wire signed [31:0] next_speedCmd = homingBusy ? rampBus.speed :
	                                   runActive ? trajSpeed + corr :
	                                   corr;
	wire signed [31:0] next_actualPos = (state == shp_pkg::HS_FINISH) ? -homeOffset :
	                                    actualPos + 32'(posDelta);

	// outputs; done set by the load wins over the clear of a fresh start
	always_ff @(posedge clk) begin
		if (!resetn) begin
			speedCmd <= 32'sh0;
			actualPos <= 32'sh0;
			homingBusy <= 1'b0;
			homingDone <= 1'b0;
		end else begin
			speedCmd <= next_speedCmd;
			actualPos <= next_actualPos;
			homingBusy <= (next_state != shp_pkg::HS_IDLE);
			if (state == shp_pkg::HS_FINISH) homingDone <= 1'b1;
			else if (homeReq && state == shp_pkg::HS_IDLE) homingDone <= 1'b0;
		end
	end

	// read data one cycle after the strobe, zero for unmapped addresses
	wire [31:0] readMux =
		(addr == shp_pkg::REG_CTRL)    ? ctrl :
		(addr == shp_pkg::REG_METHOD)  ? {30'h0, method} :
		(addr == shp_pkg::REG_SPEED1)  ? speed1 :
		(addr == shp_pkg::REG_SPEED2)  ? speed2 :
		(addr == shp_pkg::REG_ACCEL)   ? accel :
		(addr == shp_pkg::REG_OFFSET)  ? homeOffset :
		(addr == shp_pkg::REG_CURTHR)  ? {16'h0, curThr} :
		(addr == shp_pkg::REG_CORRLIM) ? corrLim :
		(addr == shp_pkg::REG_KP)      ? {16'h0, kp} :
		(addr == shp_pkg::REG_DEMPOS)  ? demPos :
		(addr == shp_pkg::REG_TRAJ)    ? trajSpeed :
		(addr == shp_pkg::REG_STATUS)  ? {30'h0, homingBusy, homingDone} :
		(addr == shp_pkg::REG_ACTPOS)  ? actualPos :
		(addr == shp_pkg::REG_SPDCMD)  ? speedCmd : 32'h0;

	always_ff @(posedge clk) begin
		if (!resetn) rdata <= 32'h0;
		else rdata <= rd ? readMux : 32'h0;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_edgeSeen;
		state == shp_pkg::HS_LOCATE && !swSel;
	endsequence
	sequence s_edgeLeft;
		s_edgeSeen ##1 state == shp_pkg::HS_FINISH;
	endsequence

	a_start_busy: assert property (state == shp_pkg::HS_IDLE && homeReq |=> homingBusy)
		else $error("homing did not start on control bit rise");
	a_approach_speed: assert property (state == shp_pkg::HS_APPROACH |->
		rampBus.target == (dirNeg ? -speed1 : speed1))
		else $error("approach not at first homing speed");
	a_locate_speed: assert property (state == shp_pkg::HS_LOCATE || state == shp_pkg::HS_PUSH |->
		rampBus.target == speed2 || rampBus.target == -speed2)
		else $error("edge search not at second homing speed");
	a_switch_end: assert property (s_edgeSeen |=> state == shp_pkg::HS_FINISH)
		else $error("homing did not end at switch transition");
	a_offset_load: assert property (s_edgeLeft |=> actualPos == -$past(homeOffset))
		else $error("position counter not loaded with negated offset");
	a_done_flag: assert property (state == shp_pkg::HS_FINISH |=> homingDone && !homingBusy)
		else $error("homing complete not shown after load");
	a_stop_detect: assert property (state == shp_pkg::HS_PUSH && stopHit |=> ##1 !homingBusy)
		else $error("mechanical stop not detected");
	a_run_bound: assert property (!homingBusy && runActive |=>
		(speedCmd - $past(trajSpeed) <= $past(corrLim)) &&
		($past(trajSpeed) - speedCmd <= $past(corrLim)))
		else $error("run correction beyond limit");
	a_hold_bound: assert property (!homingBusy && !runActive |=>
		speedCmd <= $past(corrLim) && speedCmd >= -$past(corrLim))
		else $error("holding speed beyond correction limit");
endmodule // shp_homing_loop
`default_nettype wire

// file: shp_homing_loop_tb_top.sv
/*
 * shp_homing_loop_tb_top: self-checking bench for homing and position loop.
 * Assumes shp_pkg, the ramp generator and the master model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module shp_homing_loop_tb_top;
	logic               clk;
	logic               resetn;
	logic        [7:0]  addr;
	logic        [31:0] wdata;
	logic               wr;
	logic               rd;
	logic        [31:0] rdata;
	logic               posLimit;
	logic               negLimit;
	logic        [15:0] motorCurrent;
	logic signed [31:0] motorSpeed;
	logic signed [15:0] posDelta;
	logic signed [31:0] speedCmd;
	logic signed [31:0] actualPos;
	logic               homingBusy;
	logic               homingDone;
	logic signed [31:0] accel;
	logic signed [31:0] prevSpeed;
	logic               prevBusy;
	logic               prevBusy2;
	logic signed [31:0] expPos;
	logic        [31:0] rv;
	int                 fails;
	int                 checksDone;
	int                 cycles;
	// register reset rows, the last address is unmapped
	logic [7:0]  rstAddr [8] = '{8'h00, 8'h08, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h2c, 8'h3c};
	logic [31:0] rstVal  [8] = '{0, 0, 0, 32'hffff, 32'h7530, 32'h3333, 0, 0};
	// loop rows: run bit, trajectory, position error, expected demand
	logic        runRow  [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
	logic [31:0] trajRow [4] = '{0, 0, 32'h1000, 32'h1000};
	logic [31:0] errRow  [4] = '{32'h10_0000, 32'hfff0_0000, 32'h1_0000, 32'hfff0_0000};
	logic [31:0] expRow  [4] = '{32'h7530, 32'hffff_8ad0, 32'h4333, 32'hffff_9ad0};

	shp_homing_loop #(.RAMP_TICK_CYCLES(8)) i_shp_homing_loop (.clk(clk), .resetn(resetn),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .posLimit(posLimit),
		.negLimit(negLimit), .motorCurrent(motorCurrent), .motorSpeed(motorSpeed),
		.posDelta(posDelta), .speedCmd(speedCmd), .actualPos(actualPos),
		.homingBusy(homingBusy), .homingDone(homingDone));
	shp_master i_shp_master (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata));

	// 10 MHz clock
	always #50 clk = ~clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// bounded waits; the cap stops a stuck sequencer from hanging the run
	task automatic wait_speed(input logic [31:0] exp);
		int n;
		n = 0;
		while (speedCmd !== exp && n < 300) begin
			@(posedge clk);
			n++;
		end
		check(speedCmd, exp);
	endtask

	task automatic wait_done();
		int n;
		n = 0;
		while (homingDone !== 1'b1 && n < 300) begin
			@(posedge clk);
			n++;
		end
		@(posedge clk);
		check({homingDone, homingBusy}, 2'b10);
	endtask

	// homing speed moves one acceleration step at most per cycle, plus timeout;
	// the first busy cycle still carries the loop demand, so it is skipped
	always @(posedge clk) begin
		cycles++;
		if (homingBusy === 1'b1 && prevBusy === 1'b1 && prevBusy2 === 1'b1) begin
			checksDone++;
			if (speedCmd - prevSpeed > accel || prevSpeed - speedCmd > accel) begin
				fails++;
				$display("unexpected at %0t: seen %h expected %h", $time, speedCmd, prevSpeed);
			end
		end
		prevBusy <= homingBusy;
		prevBusy2 <= prevBusy;
		prevSpeed <= speedCmd;
		if (cycles == 20000) begin
			fails++;
			test_done();
		end
	end

	// main sequence
	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		posLimit = 1'b0;
		negLimit = 1'b0;
		motorCurrent = 16'h0000;
		motorSpeed = 32'sh0;
		posDelta = 16'sh0;
		accel = 32'sh10;
		prevSpeed = 32'sh0;
		prevBusy = 1'b0;
		prevBusy2 = 1'b0;
		fails = 0;
		checksDone = 0;
		cycles = 0;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			i_shp_master.read(rstAddr[i], rv);
			check(rv, rstVal[i]);
		end
		i_shp_master.write(shp_pkg::REG_STATUS, 32'hffff_ffff);
		i_shp_master.read(shp_pkg::REG_STATUS, rv);
		check(rv, 32'h0000_0000);
		$display("register test done");
		// switch method, positive direction
		i_shp_master.write(shp_pkg::REG_SPEED1, 32'h40);
		i_shp_master.write(shp_pkg::REG_SPEED2, 32'h20);
		i_shp_master.write(shp_pkg::REG_ACCEL, accel);
		i_shp_master.set_offset(32'sh1234);
		i_shp_master.start_homing();
		wait_speed(32'h40);
		posLimit <= 1'b1;
		wait_speed(-32'sh20);
		posLimit <= 1'b0;
		wait_done();
		check(actualPos, -32'sh1234);
		i_shp_master.read(shp_pkg::REG_STATUS, rv);
		check(rv, 32'h1);
		$display("switch homing test done");
		// mechanical stop, negative direction; current alone must not end it
		i_shp_master.write(shp_pkg::REG_METHOD, 32'h3);
		i_shp_master.set_offset(32'sh100);
		i_shp_master.start_homing();
		@(posedge clk);
		check(homingDone, 1'b0);
		wait_speed(-32'sh20);
		motorCurrent <= 16'hffff;
		motorSpeed <= 32'sh7;
		repeat (20) @(posedge clk);
		check(homingBusy, 1'b1);
		motorSpeed <= 32'sh0;
		wait_done();
		check(actualPos, -32'sh100);
		motorCurrent <= 16'h0000;
		$display("stop homing test done");
		// encoder increments land in the position counter
		posDelta <= 16'sh5;
		repeat (10) @(posedge clk);
		posDelta <= 16'sh0;
		expPos = -32'sh100 + 32'sh32;
		@(posedge clk);
		check(actualPos, expPos);
		for (int i = 0; i < 4; i++) begin
			i_shp_master.write(shp_pkg::REG_TRAJ, trajRow[i]);
			i_shp_master.write(shp_pkg::REG_DEMPOS, expPos + errRow[i]);
			i_shp_master.write(shp_pkg::REG_CTRL, {31'h0, runRow[i]});
			wait_speed(expRow[i]);
		end
		$display("position loop test done");
		// reset in the middle of a stop homing run
		i_shp_master.start_homing();
		repeat (4) @(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		check({homingBusy, homingDone}, 2'b00);
		check(speedCmd, 32'h0);
		check(actualPos, 32'h0);
		resetn <= 1'b1;
		i_shp_master.read(shp_pkg::REG_CORRLIM, rv);
		check(rv, shp_pkg::RST_CORRLIM);
		$display("reset test done");
		test_done();
	end
endmodule // shp_homing_loop_tb_top
`default_nettype wire

// file: shp_master.sv
/*
 * shp_master: register master standing in for the commanding controller.
 * Assumes the device's plain register port on one rising-edge clock.
 */
`timescale 1ns/1ps
`default_nettype none
module shp_master #(
	parameter logic signed [31:0] MAX_RANGE = 32'sh0010_0000
) (
	input  wire logic        clk,
	output logic      [7:0]  addr,
	output logic      [31:0] wdata,
	output logic             wr,
	output logic             rd,
	input  wire logic [31:0] rdata
);
	// idle bus at time zero
	initial begin
		addr = 8'h00;
		wdata = 32'h0000_0000;
		wr = 1'b0;
		rd = 1'b0;
	end

	// one-cycle strobe to mapped port registers only, never tool-only settings
	// released data is inverted so stale values cannot pass
	task automatic write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		wdata <= ~d;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic read(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask

	// offset kept inside the permitted range before it is sent
	task automatic set_offset(input logic signed [31:0] d);
		if (d > MAX_RANGE) begin
			d = MAX_RANGE;
		end
		if (d < -MAX_RANGE) begin
			d = -MAX_RANGE;
		end
		write(shp_pkg::REG_OFFSET, d);
	endtask

	// start needs a 0 to 1 change, so the home bit is dropped first
	task automatic start_homing();
		write(shp_pkg::REG_CTRL, 32'h0000_0000);
		write(shp_pkg::REG_CTRL, 32'h0000_0001 << shp_pkg::CTRL_HOME_BIT);
	endtask
endmodule // shp_master
`default_nettype wire

// file: shp_pkg.sv
/*
 * shp_pkg: register map, field positions, reset values and timing constants
 * shared by the homing sequencer / position loop, its register master and bench.
 * Assumes a 10 MHz system clock and a byte-addressed plain register port.
 */
`default_nettype none
package shp_pkg;
	// clock and ramp timebase
	localparam int CLK_KHZ        = 10000;
	localparam int RAMP_TICK_US   = 1000;
	localparam int RAMP_TICK_CYCLES = (RAMP_TICK_US * CLK_KHZ) / 1000;

	// register byte offsets
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_METHOD  = 8'h04;
	localparam logic [7:0] REG_SPEED1  = 8'h08;
	localparam logic [7:0] REG_SPEED2  = 8'h0c;
	localparam logic [7:0] REG_ACCEL   = 8'h10;
	localparam logic [7:0] REG_OFFSET  = 8'h14;
	localparam logic [7:0] REG_CURTHR  = 8'h18;
	localparam logic [7:0] REG_CORRLIM = 8'h1c;
	localparam logic [7:0] REG_KP      = 8'h20;
	localparam logic [7:0] REG_DEMPOS  = 8'h24;
	localparam logic [7:0] REG_TRAJ    = 8'h28;
	localparam logic [7:0] REG_STATUS  = 8'h2c;
	localparam logic [7:0] REG_ACTPOS  = 8'h30;
	localparam logic [7:0] REG_SPDCMD  = 8'h34;

	// control and status fields
	localparam int CTRL_RUN_BIT   = 0;
	localparam int CTRL_RAMP_BIT  = 1;
	localparam int CTRL_HOME_BIT  = 4;
	localparam int STAT_DONE_BIT  = 0;
	localparam int STAT_BUSY_BIT  = 1;
	localparam int KP_FRAC        = 16;

	// homing methods: bit0 selects negative direction, bit1 mechanical stop
	localparam int METH_NEG_BIT   = 0;
	localparam int METH_STOP_BIT  = 1;

	localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
	localparam logic [31:0] RST_CORRLIM = 32'h0000_7530;
	localparam logic [15:0] RST_KP      = 16'h3333;
	localparam logic [15:0] RST_CURTHR  = 16'hffff;

	typedef enum {
		HS_IDLE, HS_APPROACH, HS_LOCATE, HS_PUSH, HS_FINISH
	} shp_home_state_t;
endpackage
`default_nettype wire

// file: shp_ramp.sv
/*
 * shp_ramp: linear speed ramp, one step of the programmed size per tick,
 * toward the target speed. Assumes tick is a one-cycle enable pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module shp_ramp (
	input  wire logic clk,
	input  wire logic resetn,
	shp_ramp_if.ramp  rb
);
	logic signed [32:0] diff;
	logic signed [32:0] stepS;
	logic signed [31:0] next_speed;

	// always linear, whatever the setpoint ramp selection says
	assign diff  = {rb.target[31], rb.target} - {rb.speed[31], rb.speed};
	assign stepS = {1'b0, rb.step};
	assign next_speed = (diff > stepS)  ? rb.speed + $signed(rb.step) :
	                    (diff < -stepS) ? rb.speed - $signed(rb.step) :
	                    rb.target;

	// same step for speeding up and slowing down
	always_ff @(posedge clk) begin
		if (!resetn || !rb.enable) begin
			rb.speed <= 32'sh0;
		end else if (rb.tick) begin
			rb.speed <= next_speed;
		end
	end

	a_ramp_step_size: assert property (@(posedge clk) disable iff (!resetn)
		rb.enable && $past(rb.enable) && rb.tick |=> 
		(rb.speed - $past(rb.speed) <= $signed($past(rb.step))) &&
		($past(rb.speed) - rb.speed <= $signed($past(rb.step))))
		else $error("ramp step exceeds acceleration");
	a_ramp_no_tick: assert property (@(posedge clk) disable iff (!resetn)
		rb.enable && !rb.tick |=> $stable(rb.speed) || !$past(rb.enable) || !rb.enable)
		else $error("ramp moved without a tick");
endmodule // shp_ramp
`default_nettype wire

// file: shp_ramp_if.sv
/*
 * shp_ramp_if: carries target speed, step and tick from the sequencer to the
 * ramp generator and the ramped speed back. Assumes one common clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface shp_ramp_if;
	logic signed [31:0] target;
	logic        [31:0] step;
	logic               tick;
	logic               enable;
	logic signed [31:0] speed;
	modport src  (output target, step, tick, enable, input speed);
	modport ramp (input target, step, tick, enable, output speed);
endinterface
`default_nettype wire
